/* design/tm2_edge_sync.sv */
// tm2_edge_sync: two-stage pin synchroniser with falling-edge detect
`timescale 1ns/10ps
`default_nettype none
module tm2_edge_sync (
  input  wire logic i_sys_clk,  // system clock
  input  wire logic i_sys_rst,  // async reset, active high
  input  wire logic i_pin,      // raw pin from outside
  output logic      o_level,    // synchronised level
  output logic      o_fall      // one-cycle pulse per falling edge
);
  logic sync_first;  // first stage, read only by second stage
  logic sync_second; // second stage
  logic sync_prev;   // previous synchronised sample

  // ********************************************************
  // synchroniser chain
  // ********************************************************
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync_first  <= 1'b1;
      sync_second <= 1'b1;
      sync_prev   <= 1'b1;
    end else begin
      sync_first  <= i_pin;
      sync_second <= sync_first;
      sync_prev   <= sync_second;
    end
  end

  // compare successive samples so one edge gives one pulse
  assign o_level = sync_second;
  assign o_fall  = sync_prev & ~sync_second;
endmodule
`default_nettype wire

/* design/tm2_prescale.sv */
// tm2_prescale: divides the system clock into the internal count tick
`timescale 1ns/10ps
`default_nettype none
module tm2_prescale
  import tm2_pkg::*;
(
  input  wire logic i_sys_clk, // system clock
  input  wire logic i_sys_rst, // async reset, active high
  output logic      o_tick     // one-cycle pulse every twelve clocks
);
  logic [3:0] div_count; // free-running divider

  // ********************************************************
  // divider
  // ********************************************************
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      div_count <= 4'h0;
    end else if (div_count == TM2_PRESCALE_DIV - 4'h1) begin
      div_count <= 4'h0;
    end else begin
      div_count <= div_count + 4'h1;
    end
  end

  assign o_tick = (div_count == TM2_PRESCALE_DIV - 4'h1);
endmodule
`default_nettype wire

/* design/tm2_timer.sv */
// tm2_timer: 16-bit timer/counter with capture, auto-reload and baud modes
//
// Summary of operation
// - clock source: internal /12 or external falls
// - capture mode without trigger: plain counter, overflow flag
// - capture mode trigger fall captures count into reload regs
// - reload mode: rollover sets flag, reloads count (all ones when down)
// - reload mode trigger fall also reloads, flags, unless down counting
// - any baud select bit: baud mode, no overflow flag
// - baud mode ignores capture select, always reloads
// - rx select bit 5 picks port one rx clock
// - tx select bit 4 picks port one tx clock
// - second bit pair steers port two clocks
// - trigger enable clear: trigger edges ignored
// - baud mode trigger fall only sets flag
// - run bit 2 starts and stops counting
// - either flag raises timer interrupt request
// - capture select: set capture, clear reload
// - capture mode counts only upward
`timescale 1ns/10ps
`default_nettype none
module tm2_timer
  import tm2_pkg::*;
(
  input  wire logic       i_sys_clk,              // system clock, 40 MHz
  input  wire logic       i_sys_rst,              // async reset, active high
  input  wire logic       i_external_count_input, // count pin
  input  wire logic       i_external_trigger_input, // trigger pin
  input  wire logic [2:0] i_reg_sel,              // register index
  input  wire logic       i_reg_wr,               // write strobe
  input  wire logic [7:0] i_reg_wdata,            // write data
  input  wire logic       i_port2_rx_baud_source, // from power_control_reg
  input  wire logic       i_port2_tx_baud_source, // from power_control_reg
  input  wire logic       i_timer1_overflow,      // timer 1 overflow pulse
  output logic      [7:0] o_reg_rdata,            // read data, one cycle late
  output logic            o_overflow_pulse,       // counter rollover pulse
  output logic            o_port1_rx_clk,         // port one receive clock
  output logic            o_port1_tx_clk,         // port one transmit clock
  output logic            o_port2_rx_clk,         // port two receive clock
  output logic            o_port2_tx_clk,         // port two transmit clock
  output logic            o_irq_request           // timer 2 interrupt request
);
  import tm2_pkg::*;

  // ********************************************************
  // state
  // ********************************************************
  tm2_ctrl_type ctrl;         // timer2_control
  logic [15:0]  count;        // count_high:count_low
  logic [15:0]  reload;       // reload_high:reload_low
  logic [7:0]   mode_ext;     // timer_mode_ext_reg
  logic [15:0]  next_count;   // count after this cycle
  tm2_mode_type mode;         // decoded operating mode
  logic         baud_any;     // any baud select bit set
  logic         down_mode;    // reload mode with down counting
  logic         count_down;   // current direction is down
  logic         pre_tick;     // internal /12 tick
  logic         cnt_fall;     // falling edge on count pin
  logic         trig_fall;    // falling edge on trigger pin
  logic         trig_level;   // synchronised trigger level
  logic         count_tick;   // counter advances this cycle
  logic         count_ovf;    // counter rolls over this cycle
  logic         trig_event;   // accepted trigger edge
  logic         set_ovf;      // hardware set of overflow flag
  logic         wr_ctrl;      // control write
  logic         wr_cnt_lo;    // count low write
  logic         wr_cnt_hi;    // count high write
  logic         wr_rel_lo;    // reload low write
  logic         wr_rel_hi;    // reload high write

  // ********************************************************
  // pin conditioning and internal tick
  // ********************************************************
  // count pin: synchronised, falls detected
  tm2_edge_sync u_count_pin (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_pin     (i_external_count_input),
    .o_level   (),
    .o_fall    (cnt_fall)
  );

  // trigger pin: level for direction, fall for events
  tm2_edge_sync u_trig_pin (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_pin     (i_external_trigger_input),
    .o_level   (trig_level),
    .o_fall    (trig_fall)
  );

  // internal tick at one twelfth of the clock
  tm2_prescale u_prescale (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .o_tick    (pre_tick)
  );

  // ********************************************************
  // register write decode
  // ********************************************************
  assign wr_ctrl   = i_reg_wr && (i_reg_sel == TM2_REG_CONTROL);
  assign wr_cnt_lo = i_reg_wr && (i_reg_sel == TM2_REG_COUNT_LO);
  assign wr_cnt_hi = i_reg_wr && (i_reg_sel == TM2_REG_COUNT_HI);
  assign wr_rel_lo = i_reg_wr && (i_reg_sel == TM2_REG_RELOAD_LO);
  assign wr_rel_hi = i_reg_wr && (i_reg_sel == TM2_REG_RELOAD_HI);

  // ********************************************************
  // mode and event decode
  // ********************************************************
  always_comb begin
    // any of four select bits forces baud mode
    baud_any = ctrl.rx_baud_source | ctrl.tx_baud_source |
               i_port2_rx_baud_source | i_port2_tx_baud_source;
    // baud overrides capture select, else it picks mode
    mode = tm2_decode_mode(baud_any, ctrl.capture_reload_select);
    // down counting only in reload mode
    down_mode = (mode == TM2_MODE_RELOAD) && mode_ext[TM2_BIT_DOWN_COUNT];
    count_down = down_mode && !trig_level;
    // count source choice, gated by run bit
    count_tick = ctrl.run_control &&
                 (ctrl.count_source_select ? cnt_fall : pre_tick);
    // rollover: up at all ones, down at the reload value
    count_ovf = count_tick &&
                (count_down ? (count == reload) : (count == TM2_COUNT_MAX));
    // trigger ignored when disabled or used as direction
    trig_event = ctrl.external_event_enable && trig_fall && !down_mode;
    // baud mode never raises the overflow flag
    set_ovf = count_ovf && (mode != TM2_MODE_BAUD);
  end

  // ********************************************************
  // next count value
  // ********************************************************
  always_comb begin
    next_count = count;
    if (count_tick) begin
      if (count_ovf) begin
        unique case (mode)
          TM2_MODE_CAPTURE: next_count = TM2_COUNT_RESET;
          TM2_MODE_RELOAD:  next_count = count_down ? TM2_COUNT_MAX : reload;
          TM2_MODE_BAUD:    next_count = reload;
        endcase
      end else begin
        // capture and baud modes only count up
        next_count = count_down ? count - 16'h0001 : count + 16'h0001;
      end
    end
    // trigger reload only in plain reload mode
    if (trig_event && (mode == TM2_MODE_RELOAD)) begin
      next_count = reload;
    end
    // software writes take the byte they address
    if (wr_cnt_lo) begin
      next_count[7:0] = i_reg_wdata;
    end
    if (wr_cnt_hi) begin
      next_count[15:8] = i_reg_wdata;
    end
  end

  // ********************************************************
  // counter register
  // ********************************************************
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      count <= TM2_COUNT_RESET;
    end else begin
      count <= next_count;
    end
  end

  // ********************************************************
  // reload / capture registers
  // ********************************************************
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      reload <= TM2_COUNT_RESET;
    end else if (trig_event && (mode == TM2_MODE_CAPTURE)) begin
      reload <= count;
    end else begin
      if (wr_rel_lo) begin
        reload[7:0] <= i_reg_wdata;
      end
      if (wr_rel_hi) begin
        reload[15:8] <= i_reg_wdata;
      end
    end
  end

  // ********************************************************
  // control and mode extension registers
  // ********************************************************
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl <= tm2_ctrl_type'(TM2_CTRL_RESET);
    end else begin
      // software write, including clearing the flags
      if (wr_ctrl) begin
        ctrl <= tm2_ctrl_type'(i_reg_wdata);
      end
      // hardware sets win over a same-cycle clear
      if (set_ovf) begin
        ctrl.overflow_flag <= 1'b1;
      end
      if (trig_event) begin
        ctrl.external_event_flag <= 1'b1;
      end
    end
  end

  // timer_mode_ext_reg holds down_count_enable
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode_ext <= TM2_MODE_EXT_RESET;
    end else if (i_reg_wr && (i_reg_sel == TM2_REG_MODE_EXT)) begin
      mode_ext <= i_reg_wdata;
    end
  end

  // ********************************************************
  // read data
  // ********************************************************
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reg_rdata <= TM2_READ_ZERO;
    end else begin
      unique case (i_reg_sel)
        TM2_REG_CONTROL:   o_reg_rdata <= ctrl;
        TM2_REG_COUNT_LO:  o_reg_rdata <= count[7:0];
        TM2_REG_COUNT_HI:  o_reg_rdata <= count[15:8];
        TM2_REG_RELOAD_LO: o_reg_rdata <= reload[7:0];
        TM2_REG_RELOAD_HI: o_reg_rdata <= reload[15:8];
        TM2_REG_MODE_EXT:  o_reg_rdata <= mode_ext;
        default:           o_reg_rdata <= TM2_READ_ZERO; // unmapped index
      endcase
    end
  end

  // ********************************************************
  // serial clock routing and interrupt request
  // ********************************************************
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_overflow_pulse <= 1'b0;
      o_port1_rx_clk   <= 1'b0;
      o_port1_tx_clk   <= 1'b0;
      o_port2_rx_clk   <= 1'b0;
      o_port2_tx_clk   <= 1'b0;
      o_irq_request    <= 1'b0;
    end else begin
      o_overflow_pulse <= count_ovf;
      o_port1_rx_clk <= ctrl.rx_baud_source ? count_ovf : i_timer1_overflow;
      o_port1_tx_clk <= ctrl.tx_baud_source ? count_ovf : i_timer1_overflow;
      o_port2_rx_clk <= i_port2_rx_baud_source ? count_ovf : i_timer1_overflow;
      o_port2_tx_clk <= i_port2_tx_baud_source ? count_ovf : i_timer1_overflow;
      o_irq_request  <= ctrl.overflow_flag | ctrl.external_event_flag;
    end
  end

  // ********************************************************
  // assertions
  // ********************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  property p_capture_copy;
    trig_event && mode == TM2_MODE_CAPTURE |=> reload == $past(count);
  endproperty
  a_capture_copy: assert property (p_capture_copy) else $error("capture missed");

  property p_ovf_flag;
    set_ovf |=> ctrl.overflow_flag ##1 o_irq_request;
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow not flagged");

  property p_baud_no_flag;
    mode == TM2_MODE_BAUD && !ctrl.overflow_flag && !wr_ctrl |=> !ctrl.overflow_flag;
  endproperty
  a_baud_no_flag: assert property (p_baud_no_flag) else $error("baud set flag");

  property p_auto_reload;
    count_ovf && mode == TM2_MODE_RELOAD && !count_down && !wr_cnt_lo && !wr_cnt_hi
      |=> count == $past(reload);
  endproperty
  a_auto_reload: assert property (p_auto_reload) else $error("no reload");

  property p_trig_ignored;
    !ctrl.external_event_enable && !ctrl.external_event_flag && !wr_ctrl
      |=> !ctrl.external_event_flag;
  endproperty
  a_trig_ignored: assert property (p_trig_ignored) else $error("trigger not ignored");

  property p_stopped;
    !ctrl.run_control && !trig_event && !wr_cnt_lo && !wr_cnt_hi |=> $stable(count);
  endproperty
  a_stopped: assert property (p_stopped) else $error("count moved while stopped");

  property p_p1_rx_clk;
    ctrl.rx_baud_source |-> (count_ovf ##1 o_port1_rx_clk) or (!count_ovf ##1 !o_port1_rx_clk);
  endproperty
  a_p1_rx_clk: assert property (p_p1_rx_clk) else $error("rx clock wrong");

  property p_p1_tx_clk;
    !ctrl.tx_baud_source && i_timer1_overflow |=> o_port1_tx_clk;
  endproperty
  a_p1_tx_clk: assert property (p_p1_tx_clk) else $error("tx clock wrong");

  property p_baud_trig_flag;
    trig_event && mode == TM2_MODE_BAUD && !count_tick |=> ctrl.external_event_flag
      && count == $past(count);
  endproperty
  a_baud_trig_flag: assert property (p_baud_trig_flag) else $error("baud trigger");

  c_capture: cover property (trig_event && mode == TM2_MODE_CAPTURE);
  c_reload_ovf: cover property (count_ovf && mode == TM2_MODE_RELOAD);
  c_baud_ovf: cover property (count_ovf && mode == TM2_MODE_BAUD);
  c_down: cover property (count_ovf && count_down);
endmodule
`default_nettype wire

/* include/tm2_pkg.sv */
// tm2_pkg: shared constants, types and decode helpers for the timer 2 block
package tm2_pkg;

  // ********************************************************
  // register indices on the special-function register port
  // ********************************************************
  localparam logic [2:0] TM2_REG_CONTROL  = 3'h0;  // timer2_control
  localparam logic [2:0] TM2_REG_COUNT_LO = 3'h1;  // count_low
  localparam logic [2:0] TM2_REG_COUNT_HI = 3'h2;  // count_high
  localparam logic [2:0] TM2_REG_RELOAD_LO = 3'h3; // reload_low
  localparam logic [2:0] TM2_REG_RELOAD_HI = 3'h4; // reload_high
  localparam logic [2:0] TM2_REG_MODE_EXT = 3'h5;  // timer_mode_ext_reg

  // ********************************************************
  // field positions, reset values and counts
  // ********************************************************
  localparam int unsigned TM2_BIT_DOWN_COUNT = 0;    // down_count_enable in mode ext
  localparam logic [7:0]  TM2_CTRL_RESET     = 8'h00;
  localparam logic [7:0]  TM2_MODE_EXT_RESET = 8'h00;
  localparam logic [15:0] TM2_COUNT_RESET    = 16'h0000;
  localparam logic [15:0] TM2_COUNT_MAX      = 16'hFFFF;
  localparam logic [3:0]  TM2_PRESCALE_DIV   = 4'hC; // internal tick is clock / 12
  localparam logic [7:0]  TM2_READ_ZERO      = 8'h00;

  // control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic overflow_flag;
    logic external_event_flag;
    logic rx_baud_source;
    logic tx_baud_source;
    logic external_event_enable;
    logic run_control;
    logic count_source_select;
    logic capture_reload_select;
  } tm2_ctrl_type;

  // operating modes, one-hot
  typedef enum logic [2:0] {
    TM2_MODE_RELOAD  = 3'b001,
    TM2_MODE_CAPTURE = 3'b010,
    TM2_MODE_BAUD    = 3'b100
  } tm2_mode_type;

  // baud use overrides the capture/reload select
  function automatic tm2_mode_type tm2_decode_mode(input logic baud_any,
                                                   input logic capture_sel);
    if (baud_any) begin
      return TM2_MODE_BAUD;
    end
    return capture_sel ? TM2_MODE_CAPTURE : TM2_MODE_RELOAD;
  endfunction

endpackage

/* tb/tb_timer2_capture_reload_baud.sv */
// tb_timer2_capture_reload_baud: self-checking bench for the timer 2 block
`timescale 1ns/10ps
`default_nettype none
module tb_timer2_capture_reload_baud;
  import tm2_pkg::*;
  // ************************************
  // signals
  // ************************************
  logic       i_sys_clk;   // 40 MHz clock
  logic       i_sys_rst;   // async reset
  logic [2:0] i_reg_sel;   // register index
  logic       i_reg_wr;    // write strobe
  logic [7:0] i_reg_wdata; // write data
  logic       p2_rx;       // port two rx select
  logic       p2_tx;       // port two tx select
  wire        cnt_pin;     // count pin from model
  wire        trig_pin;    // trigger pin from model
  wire        t1_ovf;      // timer 1 overflow from model
  logic [7:0] rdata;       // read data
  logic       ovf_p;       // rollover pulse
  logic       rx1, tx1, rx2, tx2; // port clocks
  logic       irq;         // interrupt request
  int         mismatches;  // mismatch count
  int         cmp_count;   // comparison count
  logic [15:0] v;          // scratch value
  logic [7:0]  b;          // scratch byte
  logic [15:0] w;          // second scratch value
  tm2_timer u_tm2_timer (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_external_count_input(cnt_pin), .i_external_trigger_input(trig_pin),
    .i_reg_sel(i_reg_sel), .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata),
    .i_port2_rx_baud_source(p2_rx), .i_port2_tx_baud_source(p2_tx),
    .i_timer1_overflow(t1_ovf), .o_reg_rdata(rdata), .o_overflow_pulse(ovf_p),
    .o_port1_rx_clk(rx1), .o_port1_tx_clk(tx1), .o_port2_rx_clk(rx2),
    .o_port2_tx_clk(tx2), .o_irq_request(irq));
  tm2_pin_model u_tm2_pin_model (.i_sys_clk(i_sys_clk), .o_count_pin(cnt_pin),
    .o_trig_pin(trig_pin), .o_t1_ovf(t1_ovf));
  // ************************************
  // clock and shared tasks
  // ************************************
  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  // compare and count
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one register write
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_reg_sel <= s;
    i_reg_wr <= 1'b1;
    i_reg_wdata <= d;
    @(posedge i_sys_clk) i_reg_wr <= 1'b0;
  endtask
  // one register read, data one cycle after the sampling edge
  task automatic rd(input logic [2:0] s, output logic [7:0] d);
    @(posedge i_sys_clk) i_reg_sel <= s;
    repeat (2) @(posedge i_sys_clk);
    #1 d = rdata;
  endtask
  // 16-bit pair write and read, low byte at index lo, high at lo+1
  task automatic wr16(input logic [2:0] lo, input logic [15:0] d);
    wr(lo, d[7:0]);
    wr(lo + 3'h1, d[15:8]);
  endtask
  task automatic rd16(input logic [2:0] lo, output logic [15:0] d);
    rd(lo, d[7:0]);
    rd(lo + 3'h1, d[15:8]);
  endtask
  // wait for the rollover pulse, bounded
  task automatic wait_ovf(input int lim);
    int n;
    n = 0;
    while (ovf_p !== 1'b1 && n < lim) begin
      @(posedge i_sys_clk) #1;
      n++;
    end
    chk("rollover seen", 16'h0001, {15'h0, ovf_p});
  endtask
  // ************************************
  // scenarios
  // ************************************
  task automatic t_reset();
    for (int k = 0; k < 8; k++) begin
      rd(k[2:0], b);
      chk("reset value", 16'h0000, {8'h00, b});
    end
    chk("irq after reset", 16'h0000, {15'h0, irq});
  endtask
  task automatic t_run_stop();
    wr16(TM2_REG_COUNT_LO, 16'h0000);
    wr(TM2_REG_CONTROL, 8'h04);
    repeat (240) @(posedge i_sys_clk);
    wr(TM2_REG_CONTROL, 8'h00);
    rd16(TM2_REG_COUNT_LO, v);
    cmp_count++;
    if (v < 16'h0013 || v > 16'h0015) begin
      mismatches++;
      $display("[FAIL] internal count expected 0014 seen %h", v);
    end
    repeat (60) @(posedge i_sys_clk);
    rd16(TM2_REG_COUNT_LO, w);
    chk("stopped count", v, w);
  endtask
  task automatic t_reload_ovf();
    wr16(TM2_REG_RELOAD_LO, 16'hFFF0);
    wr16(TM2_REG_COUNT_LO, 16'hFFFE);
    wr(TM2_REG_CONTROL, 8'h04);
    wait_ovf(60);
    repeat (2) @(posedge i_sys_clk) #1;
    chk("irq on overflow", 16'h0001, {15'h0, irq});
    // read the flag before software touches the register again
    rd(TM2_REG_CONTROL, b);
    chk("overflow flag", 16'h0084, {8'h00, b});
    wr(TM2_REG_CONTROL, 8'h80);
    rd16(TM2_REG_COUNT_LO, v);
    chk("reloaded count", 16'hFFF0, v);
    wr(TM2_REG_CONTROL, 8'h00);
    repeat (2) @(posedge i_sys_clk) #1;
    chk("irq cleared", 16'h0000, {15'h0, irq});
  endtask
  task automatic t_capture_roll();
    wr16(TM2_REG_COUNT_LO, 16'hFFFF);
    wr(TM2_REG_CONTROL, 8'h05);
    wait_ovf(30);
    wr(TM2_REG_CONTROL, 8'h81);
    rd16(TM2_REG_COUNT_LO, v);
    chk("capture rollover", 16'h0000, v);
    wr(TM2_REG_CONTROL, 8'h00);
  endtask
  task automatic t_capture_trig();
    wr16(TM2_REG_RELOAD_LO, 16'h0000);
    wr16(TM2_REG_COUNT_LO, 16'h1234);
    wr(TM2_REG_CONTROL, 8'h01);
    u_tm2_pin_model.trig_fall();
    rd16(TM2_REG_RELOAD_LO, v);
    chk("trigger ignored", 16'h0000, v);
    rd(TM2_REG_CONTROL, b);
    chk("no event flag", 16'h0001, {8'h00, b});
    wr(TM2_REG_CONTROL, 8'h09);
    u_tm2_pin_model.trig_fall();
    rd16(TM2_REG_RELOAD_LO, v);
    chk("captured value", 16'h1234, v);
    rd(TM2_REG_CONTROL, b);
    chk("event flag", 16'h0049, {8'h00, b});
    chk("irq on event", 16'h0001, {15'h0, irq});
    wr(TM2_REG_CONTROL, 8'h00);
  endtask
  task automatic t_reload_trig();
    wr16(TM2_REG_RELOAD_LO, 16'hABCD);
    wr16(TM2_REG_COUNT_LO, 16'h0000);
    wr(TM2_REG_CONTROL, 8'h08);
    u_tm2_pin_model.trig_fall();
    rd16(TM2_REG_COUNT_LO, v);
    chk("trigger reload", 16'hABCD, v);
    rd(TM2_REG_CONTROL, b);
    chk("event flag reload", 16'h0048, {8'h00, b});
    wr(TM2_REG_CONTROL, 8'h00);
  endtask
  task automatic t_baud();
    wr16(TM2_REG_RELOAD_LO, 16'hFFF8);
    wr16(TM2_REG_COUNT_LO, 16'hFFFE);
    wr(TM2_REG_CONTROL, 8'h3D);
    wait_ovf(60);
    chk("port1 clocks", 16'h0003, {14'h0, rx1, tx1});
    rd(TM2_REG_COUNT_HI, b);
    chk("baud reload", 16'h00FF, {8'h00, b});
    u_tm2_pin_model.trig_fall();
    rd(TM2_REG_CONTROL, b);
    chk("baud flags", 16'h007D, {8'h00, b});
    rd16(TM2_REG_RELOAD_LO, v);
    chk("no capture in baud", 16'hFFF8, v);
    wr(TM2_REG_CONTROL, 8'h00);
  endtask
  task automatic t_timer1_route();
    u_tm2_pin_model.t1_pulse();
    #1 chk("timer1 to all", 16'h000F, {12'h0, rx1, tx1, rx2, tx2});
    @(posedge i_sys_clk) p2_rx <= 1'b1;
    u_tm2_pin_model.t1_pulse();
    #1 chk("port2 rx own", 16'h000D, {12'h0, rx1, tx1, rx2, tx2});
    @(posedge i_sys_clk) p2_rx <= 1'b0;
  endtask
  task automatic t_ext_count();
    wr16(TM2_REG_COUNT_LO, 16'h0000);
    wr(TM2_REG_CONTROL, 8'h06);
    u_tm2_pin_model.count_falls(5);
    wr(TM2_REG_CONTROL, 8'h00);
    rd16(TM2_REG_COUNT_LO, v);
    chk("external count", 16'h0005, v);
  endtask
  task automatic t_down();
    wr(TM2_REG_MODE_EXT, 8'h01);
    u_tm2_pin_model.trig_level(1'b0);
    wr16(TM2_REG_RELOAD_LO, 16'h0000);
    wr16(TM2_REG_COUNT_LO, 16'h0100);
    wr(TM2_REG_CONTROL, 8'h0C);
    repeat (120) @(posedge i_sys_clk);
    // flags looked at while running, before software clears them
    rd(TM2_REG_CONTROL, b);
    chk("no flag in down", 16'h000C, {8'h00, b});
    wr(TM2_REG_CONTROL, 8'h00);
    rd16(TM2_REG_COUNT_LO, v);
    cmp_count++;
    if (v > 16'h00F8 || v < 16'h00F4) begin
      mismatches++;
      $display("[FAIL] down count expected 00F6 seen %h", v);
    end
    // capture mode with down enable and trigger low still counts up
    wr16(TM2_REG_COUNT_LO, 16'h0100);
    wr(TM2_REG_CONTROL, 8'h05);
    repeat (30) @(posedge i_sys_clk);
    wr(TM2_REG_CONTROL, 8'h00);
    rd16(TM2_REG_COUNT_LO, v);
    cmp_count++;
    if (v < 16'h0101 || v > 16'h0104) begin
      mismatches++;
      $display("[FAIL] capture up count expected 0102 seen %h", v);
    end
    u_tm2_pin_model.trig_level(1'b1);
    wr(TM2_REG_MODE_EXT, 8'h00);
  endtask
  // ************************************
  // verdict and main sequence
  // ************************************
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #(25 * 20000);
    mismatches++;
    stop_test();
  end
  initial begin
    mismatches = 0;
    cmp_count = 0;
    i_sys_rst = 1'b1;
    i_reg_sel = 3'h0;
    i_reg_wr = 1'b0;
    i_reg_wdata = 8'h00;
    p2_rx = 1'b0;
    p2_tx = 1'b0;
    repeat (10) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    t_reset();
    t_run_stop();
    t_reload_ovf();
    t_capture_roll();
    t_capture_trig();
    t_reload_trig();
    t_baud();
    t_timer1_route();
    t_ext_count();
    t_down();
    stop_test();
  end
endmodule
`default_nettype wire

/* tb/tm2_pin_model.sv */
// tm2_pin_model: drives the trigger, count and timer 1 overflow inputs
`timescale 1ns/10ps
`default_nettype none
module tm2_pin_model (
  input  wire logic i_sys_clk,  // system clock
  output logic      o_count_pin, // count pin, idles high (pull-up)
  output logic      o_trig_pin,  // trigger pin, idles high (pull-up)
  output logic      o_t1_ovf     // timer 1 overflow pulse
);
  // ************************************
  // pins idle high, no pulse
  // ************************************
  initial begin
    o_count_pin = 1'b1;
    o_trig_pin  = 1'b1;
    o_t1_ovf    = 1'b0;
  end
  // n falls, 12 clocks low and 12 high: no faster than clock / 24
  task automatic count_falls(input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge i_sys_clk) o_count_pin <= 1'b0;
      repeat (12) @(posedge i_sys_clk);
      o_count_pin <= 1'b1;
      repeat (12) @(posedge i_sys_clk);
    end
  endtask
  // one trigger fall, held low long enough for the synchroniser
  task automatic trig_fall();
    @(posedge i_sys_clk) o_trig_pin <= 1'b0;
    repeat (12) @(posedge i_sys_clk);
    o_trig_pin <= 1'b1;
    repeat (12) @(posedge i_sys_clk);
  endtask
  // static trigger level, used as direction in down mode
  task automatic trig_level(input logic v);
    @(posedge i_sys_clk) o_trig_pin <= v;
  endtask
  // one-cycle timer 1 overflow pulse
  task automatic t1_pulse();
    @(posedge i_sys_clk) o_t1_ovf <= 1'b1;
    @(posedge i_sys_clk) o_t1_ovf <= 1'b0;
  endtask
endmodule
`default_nettype wire
